// [rtl/cfg_guard_pkg.sv]
// Package of register map, field layout and reset values for the config guard
package cfg_guard_pkg;
   localparam int ADDR_W = 32;
   localparam logic [31:0] STRAP_STATUS_ADDR = 32'h01b3f004;
   localparam logic [31:0] GUARD_ADDR = 32'h01b3f018;
   localparam logic [31:0] PERIPH_EN_ADDR = 32'h01b3f000;
   localparam logic [31:0] UNLOCK_KEY = 32'h10c0010c;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int PEN_W = 6;
   // Video ports and two-wire off; serial ports selected, audio off
   localparam logic [5:0] PEN_RESET = 6'h06;
   localparam int STRAP_W = 11;
   localparam int GUARD_BIT = 0;

   typedef struct packed {
      logic net_mac_on;
      logic host_port_width;
      logic pci_eeprom_autoload;
      logic pci_on;
      logic [1:0] cpu_clock_multiplier;
      logic little_endian_flag;
      logic [1:0] boot_source;
      logic [1:0] ext_mem_clock_select;
   } strap_type;

   typedef struct packed {
      logic video_port1_on;
      logic video_port0_on;
      logic two_wire_on;
      logic serial_port1_select;
      logic serial_port0_select;
      logic audio_port_select;
   } pen_type;

   function automatic logic [31:0] strap_word(input strap_type s);
      strap_word = {20'h00000, s.net_mac_on, s.host_port_width,
         s.pci_eeprom_autoload, s.pci_on, 1'b0, s.cpu_clock_multiplier,
         s.little_endian_flag, s.boot_source, s.ext_mem_clock_select};
   endfunction : strap_word
endpackage : cfg_guard_pkg

// [rtl/strap_capture.sv]
// Capture of strap pin levels once after reset release
`timescale 1ns/10ps
module strap_capture
   import cfg_guard_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Strap pins
   input wire strap_type pins_i,
   // Held value
   output strap_type strap_o
);
   logic done_q;

   // Reset can only load constants, so the pins are sampled on the first edge
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         done_q <= 1'b0;
         strap_o <= '0;
      end else if (!done_q) begin
         done_q <= 1'b1;
         strap_o <= pins_i;
      end
   end
endmodule : strap_capture

// [rtl/periph_config_lock_status.sv]
// Configuration write guard and strap status register bank over AXI4-Lite
//
// Behaviour
// - Guard bit 0 reads 1 when locked, 0 unlocked; locked after reset.
// - Enable register writes are dropped while locked.
// - Enable register reads always return its contents.
// - Full 32-bit key write unlocks; software writes key before enables.
// - Any enable register write relocks the guard.
// - Reserved bits read zero, writes ignored.
// - Status bit 11 shows network MAC enable.
// - Status bit 10 shows host port width, 0 is 16-bit.
// - Status bit 9 shows PCI EEPROM autoload.
// - Status bit 8 shows PCI enable.
// - Status bits 6:5 show CPU clock multiplier.
// - Status bit 4 shows byte order, 1 little-endian.
// - Status bits 3:2 show boot source.
// - Status bits 1:0 show external memory clock source.
// - Status register is read-only, shows current configuration.
// - Enable register holds six peripheral enable and select bits.
// - Serial port selects set at power-up, other bits clear; enable bits change only while unlocked.
`timescale 1ns/10ps
module periph_config_lock_status
   import cfg_guard_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // AXI4-Lite write address
   input wire logic [31:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   // AXI4-Lite read address
   input wire logic [31:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   // Strap pins
   input wire strap_type strap_pins_i,
   // Peripheral enables and lock state flag
   output pen_type periph_enable_o,
   output logic lock_state_flag_o
);

   ////////////////////////////////////////////////////////////////////
   logic aw_held_q;
   logic w_held_q;
   logic [31:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic do_write;
   logic lock_q;
   strap_type strap;

   strap_capture u_strap (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pins_i(strap_pins_i),
      .strap_o(strap)
   );

   ////////////////////////////////////////////////////////////////////
   // Write channel: address and data latched in either order
   assign do_write = aw_held_q && w_held_q && !s_axi_bvalid_o;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         aw_held_q <= 1'b0;
         awaddr_q <= '0;
         s_axi_awready_o <= 1'b0;
      end else begin
         // Stay closed while a response waits: one write at a time
         s_axi_awready_o <= !aw_held_q && !s_axi_awready_o &&
                            !s_axi_bvalid_o;
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_held_q <= 1'b1;
            awaddr_q <= s_axi_awaddr_i;
            s_axi_awready_o <= 1'b0;
         end else if (do_write) begin
            aw_held_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         w_held_q <= 1'b0;
         wdata_q <= '0;
         wstrb_q <= '0;
         s_axi_wready_o <= 1'b0;
      end else begin
         s_axi_wready_o <= !w_held_q && !s_axi_wready_o &&
                           !s_axi_bvalid_o;
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata_i;
            wstrb_q <= s_axi_wstrb_i;
            s_axi_wready_o <= 1'b0;
         end else if (do_write) begin
            w_held_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid_o <= 1'b1;
         if (awaddr_q == GUARD_ADDR || awaddr_q == PERIPH_EN_ADDR ||
             awaddr_q == STRAP_STATUS_ADDR) begin
            s_axi_bresp_o <= RESP_OKAY;
         end else begin
            s_axi_bresp_o <= RESP_SLVERR;
         end
      end else if (s_axi_bready_i) begin
         s_axi_bvalid_o <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Guard: only the complete key unlocks, so all byte lanes are required
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         lock_q <= 1'b1;
      end else if (do_write && awaddr_q == GUARD_ADDR) begin
         lock_q <= !(wdata_q == UNLOCK_KEY && wstrb_q == 4'hf);
      end else if (do_write && awaddr_q == PERIPH_EN_ADDR) begin
         lock_q <= 1'b1;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         lock_state_flag_o <= 1'b1;
      end else begin
         lock_state_flag_o <= lock_q;
      end
   end

   // Enable register; strobe on byte 0 needed since all bits live there
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         periph_enable_o <= pen_type'(PEN_RESET);
      end else if (do_write && awaddr_q == PERIPH_EN_ADDR && !lock_q &&
                   wstrb_q[0]) begin
         periph_enable_o <= pen_type'(wdata_q[PEN_W-1:0]);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Read channel: one read at a time, rvalid raised at the edge that accepts it
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o <= '0;
         s_axi_rresp_o <= RESP_OKAY;
      end else begin
         s_axi_arready_o <= !s_axi_rvalid_o && !s_axi_arready_o &&
                            !(s_axi_arvalid_i && s_axi_arready_o);
         if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b1;
            s_axi_rresp_o <= RESP_OKAY;
            if (s_axi_araddr_i == GUARD_ADDR) begin
               s_axi_rdata_o <= {31'h00000000, lock_q};
            end else if (s_axi_araddr_i == PERIPH_EN_ADDR) begin
               s_axi_rdata_o <= {26'h0000000, periph_enable_o};
            end else if (s_axi_araddr_i == STRAP_STATUS_ADDR) begin
               s_axi_rdata_o <= strap_word(strap);
            end else begin
               s_axi_rdata_o <= '0;
               s_axi_rresp_o <= RESP_SLVERR;
            end
         end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
         end
      end
   end
endmodule : periph_config_lock_status

// [test/periph_config_lock_status_asserts.sv]
// Checker of handshake and guard behaviour at the bank's ports
`timescale 1ns/10ps
module periph_config_lock_status_asserts
   import cfg_guard_pkg::*;
(
   input wire logic clk_i, rst_i, s_axi_bready_i, s_axi_rready_i,
   input wire logic s_axi_arvalid_i, s_axi_awready_o, s_axi_wready_o,
   input wire logic s_axi_arready_o, s_axi_bvalid_o, s_axi_rvalid_o,
   input wire logic lock_state_flag_o,
   input wire logic [31:0] s_axi_rdata_o,
   input wire pen_type periph_enable_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_lock_holds_pen: assert property (lock_state_flag_o
      |=> $stable(periph_enable_o)) else $error("pen moved");
   a_change_relocks: assert property ($changed(periph_enable_o)
      |-> ##[1:2] lock_state_flag_o) else $error("no relock");
   a_unlock_on_resp: assert property ($fell(lock_state_flag_o)
      |-> s_axi_bvalid_o || $past(s_axi_bvalid_o)) else $error("unlock");
   a_relock_on_resp: assert property ($rose(lock_state_flag_o)
      |-> s_axi_bvalid_o || $past(s_axi_bvalid_o)) else $error("relock");
   a_bresp_held: assert property (s_axi_bvalid_o && !s_axi_bready_i
      |=> s_axi_bvalid_o) else $error("bvalid dropped");
   a_rdata_held: assert property (s_axi_rvalid_o && !s_axi_rready_i
      |=> s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("rdata");
   a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o
      |=> s_axi_rvalid_o) else $error("late read");
   a_write_busy: assert property (s_axi_bvalid_o
      |-> !s_axi_awready_o && !s_axi_wready_o) else $error("overlap");
endmodule : periph_config_lock_status_asserts

bind periph_config_lock_status periph_config_lock_status_asserts u_chk (.*);

// [test/axil_host.sv]
// Behavioural AXI4-Lite host issuing one access per xfer call
`timescale 1ns/10ps
module axil_host (
   input wire logic clk_i, s_axi_awready_o, s_axi_wready_o,
   input wire logic s_axi_arready_o, s_axi_bvalid_o, s_axi_rvalid_o,
   input wire logic [1:0] s_axi_bresp_o, s_axi_rresp_o,
   input wire logic [31:0] s_axi_rdata_o,
   output logic [31:0] s_axi_awaddr_i = '0, s_axi_araddr_i = '0,
   output logic [31:0] s_axi_wdata_i = '0,
   output logic [3:0] s_axi_wstrb_i = '0,
   output logic s_axi_awvalid_i = '0, s_axi_wvalid_i = '0,
   output logic s_axi_arvalid_i = '0, s_axi_bready_i = '0,
   output logic s_axi_rready_i = '0
);
   bit hang;
   // Ready comes w cycles late so the slave must hold its answer
   task automatic xfer(input logic wr, input logic [31:0] a, d,
      input logic [3:0] s, input int w, output logic [31:0] q,
      output logic [1:0] r);
      int n = 0;
      logic done = 1'b0;
      @(posedge clk_i);
      s_axi_awaddr_i <= a;
      s_axi_araddr_i <= a;
      s_axi_wdata_i <= d;
      s_axi_wstrb_i <= s;
      s_axi_awvalid_i <= wr;
      s_axi_wvalid_i <= wr;
      s_axi_arvalid_i <= !wr;
      do begin
         @(posedge clk_i);
         n++;
         // Answer taken at this edge: ready is released only after the loop
         done = s_axi_bready_i && s_axi_bvalid_o ||
            s_axi_rready_i && s_axi_rvalid_o;
         if (s_axi_awready_o) s_axi_awvalid_i <= '0;
         if (s_axi_wready_o) s_axi_wvalid_i <= '0;
         if (s_axi_arready_o) s_axi_arvalid_i <= '0;
         if (!done && n > w) s_axi_bready_i <= wr;
         if (!done && n > w) s_axi_rready_i <= !wr;
      end while (!done && n < 99);
      hang = !done;
      s_axi_bready_i <= '0;
      s_axi_rready_i <= '0;
      q = s_axi_rdata_o;
      r = wr ? s_axi_bresp_o : s_axi_rresp_o;
   endtask : xfer
endmodule : axil_host

// [test/periph_config_lock_status_tb.sv]
// Self-checking bench of the guard bank against a reference model
`timescale 1ns/10ps
module periph_config_lock_status_tb;
   import cfg_guard_pkg::*;
   logic clk_i = '0, rst_i = '1, lock_state_flag_o, lk;
   logic [31:0] s_axi_awaddr_i, s_axi_wdata_i, s_axi_araddr_i, s_axi_rdata_o;
   logic [3:0] s_axi_wstrb_i, st;
   logic [1:0] s_axi_bresp_o, s_axi_rresp_o, r;
   logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o;
   logic s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o;
   logic s_axi_rvalid_o, s_axi_rready_i;
   strap_type strap_pins_i = '0;
   pen_type periph_enable_o;
   int fail_count = 0, n_checks = 0, seed = 13318, j;
   logic [31:0] q, dt, e, adr [4];
   logic [10:0] v;
   logic [5:0] pm;
   always #10 clk_i = ~clk_i;
   periph_config_lock_status u_dut (.*);
   axil_host u_host (.*);
   ////////////////////////////////////////////////////////////////////////
   task automatic end_of_test;
      if (fail_count == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : end_of_test
   task automatic cmp_word(input logic [31:0] got, exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp_word
   // Model updates before the compare; outputs checked once settled
   task automatic bus(input logic wr, input logic [31:0] a, d,
      input logic [3:0] s);
      u_host.xfer(wr, a, d, s, $unsigned($random(seed)) % 3, q, r);
      if (u_host.hang) begin
         fail_count++;
         end_of_test();
      end
      e = '0;
      if (a == GUARD_ADDR && wr) lk = !(d == UNLOCK_KEY && s == 4'hf);
      if (a == PERIPH_EN_ADDR && wr && !lk && s[0]) pm = d[5:0];
      if (a == PERIPH_EN_ADDR) lk = lk | wr;
      if (a == GUARD_ADDR) e[0] = lk;
      if (a == PERIPH_EN_ADDR) e[5:0] = pm;
      if (a == STRAP_STATUS_ADDR) e[11:0] = {v[10:7], 1'b0, v[6:0]};
      cmp_word(32'(r), 32'(a == adr[3] ? RESP_SLVERR : RESP_OKAY));
      if (!wr) cmp_word(q, e);
      repeat (2) @(posedge clk_i);
      cmp_word(32'(periph_enable_o), 32'(pm));
      cmp_word(32'(lock_state_flag_o), 32'(lk));
   endtask : bus
   ////////////////////////////////////////////////////////////////////////
   initial begin
      // The bank's three registers plus one unmapped address that must answer SLVERR
      adr = '{PERIPH_EN_ADDR, GUARD_ADDR, STRAP_STATUS_ADDR, 32'h01b3f010};
      for (int k = 0; k < 4; k++) begin
         v = 11'($random(seed));
         v[6:0] = {k[1:0], v[4], k[1:0], k[1:0]};
         rst_i <= '1;
         strap_pins_i <= v;
         lk = '1;
         pm = 6'h06;
         repeat (10) @(posedge clk_i);
         rst_i <= '0;
         repeat (2) @(posedge clk_i);
         strap_pins_i <= ~v;
         bus(0, GUARD_ADDR, 0, 0);
         bus(0, STRAP_STATUS_ADDR, 0, 0);
         bus(1, PERIPH_EN_ADDR, '1, 4'hf);
         bus(1, GUARD_ADDR, ~UNLOCK_KEY, 4'hf);
         bus(1, GUARD_ADDR, UNLOCK_KEY, 4'h7);
         bus(1, PERIPH_EN_ADDR, '1, 4'hf);
         bus(1, STRAP_STATUS_ADDR, '1, 4'hf);
         bus(0, STRAP_STATUS_ADDR, 0, 0);
         bus(1, adr[3], 0, 4'hf);
         bus(0, adr[3], 0, 0);
         bus(1, GUARD_ADDR, UNLOCK_KEY, 4'hf);
         bus(0, PERIPH_EN_ADDR, 0, 0);
         bus(1, PERIPH_EN_ADDR, $random(seed), 4'hf);
         bus(0, PERIPH_EN_ADDR, 0, 0);
         repeat (128) @(posedge clk_i);
         for (int i = 0; i < 30; i++) begin
            j = $unsigned($random(seed)) % 4;
            dt = (j == 1) ? UNLOCK_KEY : $random(seed);
            st = (j == 1) ? 4'hf : 4'($random(seed));
            bus(1'($random(seed)), adr[j], dt, st);
         end
      end
      end_of_test();
   end
endmodule : periph_config_lock_status_tb
